// file: core/duc_pkg.sv
// Operation
// R1: Output clear low grounds every channel output and floats its buffer.
// R2: Load strobe pulses are ignored while output clear is low.
// R3: Clear released with strobe high keeps outputs cleared until strobe falls.
// R4: Strobe tied low: releasing clear restores outputs from channel latches.
// R5: Output clear never alters zero, gain, input, data registers or latches.
// R6: Power-on loads offset, data registers and latches from the select pin; the code sets the offset from format and supply only.
// R7: Power-on or hardware reset clears the input data register to zero.
// R8: Dual supply reset codes follow select and format; offset 99A or 19A.
// R9: Single supply turns offset off; same data code mapping applies.
// R10: Hardware reset low forces outputs, registers and latches to reset values.
// R11: Serial interface is disabled and its output floated during hardware reset.
// R12: After reset release outputs keep reset values and serial resumes.
// R13: Host keeps chip select high whenever it drives hardware reset.
// R14: Update mode is latched once at power-on from the load strobe level.
// R15: Only channels accessed since the last load get their latch reloaded; the code reloads every channel while the software load bit is set.
// R16: Asynchronous mode ignores load bit and strobe; updates on select rising.
// R17: Asynchronous with correction on updates each latch when its write lands.
// R18: Synchronous, correction off: strobe fall or load bit updates all at once.
// R19: Synchronous, correction on: update waits for correction writes to finish.
// R20: Host holds strobe high before select falls and waits before loading.
// R21: Monitor output floats when disabled, else routes the selected source.
// R22: Group power-down grounds outputs; recovery completes within 200 us.
// R23: Serial word is written to its register on chip select rising.
// R24: Hardware reset is synchronised and released synchronously.
package duc_pkg;
    localparam int          CHANNELS      = 8;
    localparam int          DW            = 12;
    localparam int          ADDR_W        = 3;
    localparam int          GROUP_SPLIT   = 4;
    localparam logic [11:0] CODE_ZERO     = 12'h000;
    localparam logic [11:0] CODE_MID      = 12'h800;
    localparam logic [11:0] OFFSET_BIN    = 12'h99A;
    localparam logic [11:0] OFFSET_TWOS   = 12'h19A;
    localparam logic [11:0] OFFSET_OFF    = 12'h000;
    localparam logic [11:0] GAIN_DEFAULT  = 12'hFFF;
    localparam logic [11:0] ZERO_DEFAULT  = 12'h000;
    localparam int          CLK_MHZ       = 100;
    localparam int          RECOVER_US    = 200;
    localparam int          RECOVER_CYC   = RECOVER_US * CLK_MHZ;
    localparam int          REC_W         = 15;
    localparam logic [3:0]  MON_SRC_AUX0  = 4'h8;
    localparam logic [3:0]  MON_SRC_AUX1  = 4'h9;
    localparam logic [3:0]  MON_SRC_OFFA  = 4'hA;
    localparam logic [3:0]  MON_SRC_OFFB  = 4'hB;
    localparam logic [3:0]  MON_SRC_REFA  = 4'hC;
    localparam logic [3:0]  MON_SRC_REFB  = 4'hD;

    typedef enum logic [1:0] {DUC_NORMAL, DUC_CLEARED, DUC_WAIT_FALL} duc_clr_t;

    typedef struct packed {
        logic             valid;
        logic [ADDR_W-1:0] chan;
        logic [DW-1:0]    data;
    } duc_write_t;

    typedef struct packed {
        logic [1:0]  rst_sync;
        logic [1:0]  cs_sync;
        logic [1:0]  ld_sync;
        logic [1:0]  clr_sync;
        logic        ld_prev;
        logic        cs_prev;
        logic        in_reset;
        logic        mode_taken;
        logic        async_mode;
        duc_clr_t    clr_state;
        logic [CHANNELS-1:0]        accessed;
        logic [CHANNELS-1:0][DW-1:0] data_reg;
        logic [CHANNELS-1:0][DW-1:0] latch;
        logic [DW-1:0] input_reg;
        logic [DW-1:0] gain_reg;
        logic [DW-1:0] zero_reg;
        logic [DW-1:0] offset_reg;
        logic          pend_load;
        logic [1:0]    pd_prev;
        logic [1:0][REC_W-1:0] recover;
        logic [CHANNELS-1:0][DW-1:0] out_code;
        logic [CHANNELS-1:0] out_ground;
        logic          sdo_oe;
        logic          mon_oe;
        logic [3:0]    mon_sel;
        logic          ready;
    } duc_state_t;
endpackage

// file: core/duc_update_ctrl.sv
`timescale 1ns/1ps
module duc_update_ctrl (
    input  wire logic                     mclk_in,
    input  wire logic                     sys_rst_in,
    input  wire logic                     clk_en_in,
    input  wire logic                     hw_reset_n_in,
    input  wire logic                     output_clear_n_in,
    input  wire logic                     load_strobe_n_in,
    input  wire logic                     chip_select_n_in,
    input  wire logic                     reset_level_select_in,
    input  wire logic                     data_format_select_in,
    input  wire logic                     single_supply_in,
    input  wire duc_pkg::duc_write_t      wr_in,
    input  wire logic                     input_reg_wr_in,
    input  wire logic                     software_load_bit_in,
    input  wire logic                     correction_engine_enable_in,
    input  wire logic                     corr_done_in,
    input  wire logic [duc_pkg::ADDR_W-1:0] corr_chan_in,
    input  wire logic [1:0]               group_powerdown_bit_in,
    input  wire logic                     monitor_enable_in,
    input  wire logic [3:0]               monitor_select_in,
    output logic [duc_pkg::CHANNELS*duc_pkg::DW-1:0] channel_output_code_out,
    output logic [duc_pkg::CHANNELS-1:0]  channel_output_ground_out,
    output logic [duc_pkg::DW-1:0]        offset_code_out,
    output logic [duc_pkg::DW-1:0]        input_reg_out,
    output logic                          serial_enable_out,
    output logic                          sdo_oe_out,
    output logic                          monitor_output_oe_out,
    output logic [3:0]                    monitor_output_sel_out,
    output logic                          async_mode_out
);
    duc_pkg::duc_state_t s;
    duc_pkg::duc_state_t next_s;
    logic                run_ok;
    logic [duc_pkg::DW-1:0] rst_expect;

    assign run_ok     = clk_en_in && s.rst_sync[1] && s.mode_taken;
    assign rst_expect = (reset_level_select_in != data_format_select_in) ? duc_pkg::CODE_MID :
                        duc_pkg::CODE_ZERO;

    ////////////////////////////////////////////////////////////////////////
    // Update logic. Data and latch defaults come from the select and format
    // pins; the formats invert each other's code, hence the exclusive-or.
    always_comb begin
        logic [duc_pkg::DW-1:0] rst_code;
        logic                   rst_now;
        logic                   cs_rise;
        logic                   ld_fall;
        logic                   do_all;
        logic                   clr_low;
        rst_code = (reset_level_select_in ^ data_format_select_in) ?
                   duc_pkg::CODE_MID : duc_pkg::CODE_ZERO; // R8 R9
        next_s = s;
        next_s.rst_sync = {s.rst_sync[0], hw_reset_n_in}; // R24
        next_s.cs_sync  = {s.cs_sync[0], chip_select_n_in};
        next_s.ld_sync  = {s.ld_sync[0], load_strobe_n_in};
        next_s.clr_sync = {s.clr_sync[0], output_clear_n_in};
        next_s.ld_prev  = s.ld_sync[1];
        next_s.cs_prev  = s.cs_sync[1];
        rst_now = !s.rst_sync[1] || !s.mode_taken;
        cs_rise = s.cs_sync[1] && !s.cs_prev;
        ld_fall = !s.ld_sync[1] && s.ld_prev;
        clr_low = !s.clr_sync[1];
        do_all  = 1'b0;
        if (!s.mode_taken && s.rst_sync[1]) begin
            // Sampled once the reset chain has filled, so the strobe chain holds the pin level.
            next_s.mode_taken = 1'b1; // R14
            next_s.async_mode = !s.ld_sync[1]; // R14
        end
        next_s.in_reset = rst_now;
        if (rst_now) begin
            next_s.data_reg   = {duc_pkg::CHANNELS{rst_code}}; // R6 R10
            next_s.latch      = {duc_pkg::CHANNELS{rst_code}}; // R6 R10
            next_s.input_reg  = duc_pkg::CODE_ZERO; // R7
            next_s.gain_reg   = duc_pkg::GAIN_DEFAULT; // R10
            next_s.zero_reg   = duc_pkg::ZERO_DEFAULT; // R10
            next_s.offset_reg = single_supply_in ? duc_pkg::OFFSET_OFF :
                                data_format_select_in ? duc_pkg::OFFSET_TWOS :
                                duc_pkg::OFFSET_BIN; // R8 R9
            next_s.accessed   = '0;
            next_s.pend_load  = 1'b0;
        end else begin
            // Written regardless of clear level, so clear leaves them intact.
            if (cs_rise && wr_in.valid) begin
                next_s.data_reg[wr_in.chan] = wr_in.data; // R23 R5
                next_s.accessed[wr_in.chan] = 1'b1; // R15
                if (s.async_mode && !correction_engine_enable_in) begin
                    next_s.latch[wr_in.chan] = wr_in.data; // R16
                    next_s.accessed[wr_in.chan] = 1'b0;
                end
            end
            if (cs_rise && input_reg_wr_in) begin
                next_s.input_reg = wr_in.data; // R23
            end
            if (s.async_mode && correction_engine_enable_in && corr_done_in) begin
                next_s.latch[corr_chan_in] = s.data_reg[corr_chan_in]; // R17
                next_s.accessed[corr_chan_in] = 1'b0;
            end
            if (!s.async_mode && !clr_low) begin
                if (ld_fall || software_load_bit_in) begin
                    next_s.pend_load = 1'b1; // R18 R2
                end
            end
            if (s.pend_load && (!correction_engine_enable_in || corr_done_in)) begin
                do_all = 1'b1; // R19
                next_s.pend_load = 1'b0;
            end
            if (do_all) begin
                for (int i = 0; i < duc_pkg::CHANNELS; i++) begin
                    if (s.accessed[i] || software_load_bit_in) begin
                        next_s.latch[i] = next_s.data_reg[i]; // R15
                    end
                end
                next_s.accessed = '0;
            end
        end
        // Clear tracking; strobe falls do not load while clear is low, but do load in the wait-for-fall state.
        case (s.clr_state)
            duc_pkg::DUC_NORMAL: begin
                if (clr_low) next_s.clr_state = duc_pkg::DUC_CLEARED; // R1
            end
            duc_pkg::DUC_CLEARED: begin
                if (!clr_low) begin
                    next_s.clr_state = s.ld_sync[1] ? duc_pkg::DUC_WAIT_FALL :
                                       duc_pkg::DUC_NORMAL; // R3 R4
                end
            end
            duc_pkg::DUC_WAIT_FALL: begin
                if (clr_low) next_s.clr_state = duc_pkg::DUC_CLEARED;
                else if (!s.ld_sync[1]) next_s.clr_state = duc_pkg::DUC_NORMAL; // R3
            end
            default: next_s.clr_state = duc_pkg::DUC_NORMAL;
        endcase
        for (int g = 0; g < 2; g++) begin
            next_s.pd_prev[g] = group_powerdown_bit_in[g];
            if (s.pd_prev[g] && !group_powerdown_bit_in[g]) begin
                next_s.recover[g] = duc_pkg::REC_W'(duc_pkg::RECOVER_CYC); // R22
            end else if (s.recover[g] != '0) begin
                next_s.recover[g] = s.recover[g] - 1'b1;
            end
        end
        for (int i = 0; i < duc_pkg::CHANNELS; i++) begin
            logic pd;
            pd = (i < duc_pkg::GROUP_SPLIT) ? group_powerdown_bit_in[0] :
                 group_powerdown_bit_in[1];
            next_s.out_ground[i] = rst_now ? 1'b0 :
                (s.clr_state != duc_pkg::DUC_NORMAL) || clr_low || pd; // R1 R22
            next_s.out_code[i] = next_s.latch[i]; // R12
        end
        next_s.ready   = !rst_now && !s.in_reset; // R11 R12
        next_s.sdo_oe  = !rst_now && !s.cs_sync[1]; // R11
        next_s.mon_oe  = monitor_enable_in; // R21
        next_s.mon_sel = monitor_select_in; // R21
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s          <= '0;
            s.rst_sync <= 2'b00;
            s.cs_sync  <= 2'b11;
            s.ld_sync  <= 2'b11;
            s.clr_sync <= 2'b11;
            s.ld_prev  <= 1'b1;
            s.cs_prev  <= 1'b1;
            s.in_reset <= 1'b1;
            s.clr_state <= duc_pkg::DUC_NORMAL;
        end else if (clk_en_in) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign channel_output_code_out   = s.out_code;
    assign channel_output_ground_out = s.out_ground;
    assign offset_code_out           = s.offset_reg;
    assign input_reg_out             = s.input_reg;
    assign serial_enable_out         = s.ready;
    assign sdo_oe_out                = s.sdo_oe;
    assign monitor_output_oe_out     = s.mon_oe;
    assign monitor_output_sel_out    = s.mon_sel;
    assign async_mode_out            = s.async_mode;

    ////////////////////////////////////////////////////////////////////////
    property p_clr_ground; // R1
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && !s.clr_sync[1] && !s.in_reset) |=> (&s.out_ground);
    endproperty
    a_clr_ground: assert property (p_clr_ground) // R1
        else $error("Clear did not ground outputs.");

    property p_clr_keeps; // R5
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && !s.clr_sync[1] && s.rst_sync[1] && s.mode_taken
         && !(s.cs_sync[1] && !s.cs_prev) && !s.async_mode) |=> $stable(s.data_reg);
    endproperty
    a_clr_keeps: assert property (p_clr_keeps) // R5
        else $error("Clear altered data registers.");

    property p_no_load_clr; // R2
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && !s.clr_sync[1] && !s.pend_load && s.mode_taken) |=> !s.pend_load;
    endproperty
    a_no_load_clr: assert property (p_no_load_clr) // R2
        else $error("Load taken while cleared.");

    property p_wait_fall; // R3
        @(posedge mclk_in) disable iff (sys_rst_in)
        (s.clr_state == duc_pkg::DUC_WAIT_FALL) |-> s.out_ground == '1 || !clk_en_in ||
        $past(s.clr_state) != duc_pkg::DUC_WAIT_FALL;
    endproperty
    a_wait_fall: assert property (p_wait_fall) // R3
        else $error("Outputs released before strobe fell.");

    property p_reset_input; // R7
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && !s.rst_sync[1]) |=> s.input_reg == duc_pkg::CODE_ZERO;
    endproperty
    a_reset_input: assert property (p_reset_input) // R7
        else $error("Input register not cleared.");

    property p_sdo_reset; // R11
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && !s.rst_sync[1]) |=> !s.sdo_oe && !s.ready;
    endproperty
    a_sdo_reset: assert property (p_sdo_reset) // R11
        else $error("Serial active during reset.");

    property p_mode_once; // R14
        @(posedge mclk_in) disable iff (sys_rst_in)
        s.mode_taken |=> $stable(s.async_mode);
    endproperty
    a_mode_once: assert property (p_mode_once) // R14
        else $error("Update mode changed after power-on.");

    property p_mon_oe; // R21
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && !monitor_enable_in) |=> !monitor_output_oe_out;
    endproperty
    a_mon_oe: assert property (p_mon_oe) // R21
        else $error("Monitor driven while disabled.");

    property p_pd_ground; // R22
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && group_powerdown_bit_in[0] && s.mode_taken && s.rst_sync[1])
        |=> s.out_ground[0];
    endproperty
    a_pd_ground: assert property (p_pd_ground) // R22
        else $error("Powered-down group not grounded.");

    property p_rst_data;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && !s.rst_sync[1])
        |=> s.latch == {duc_pkg::CHANNELS{rst_expect}};
    endproperty
    a_rst_data: assert property (p_rst_data) // R6
        else $error("Latches not at reset code.");

    property p_rst_gain;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && !s.rst_sync[1])
        |=> s.gain_reg == duc_pkg::GAIN_DEFAULT && s.zero_reg == duc_pkg::ZERO_DEFAULT;
    endproperty
    a_rst_gain: assert property (p_rst_gain) // R10
        else $error("Gain or zero register not at default.");

    property p_rst_offset;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && !s.rst_sync[1]) |=> s.offset_reg == (single_supply_in ?
        duc_pkg::OFFSET_OFF : data_format_select_in ? duc_pkg::OFFSET_TWOS : duc_pkg::OFFSET_BIN);
    endproperty
    a_rst_offset: assert property (p_rst_offset) // R8
        else $error("Offset register not at reset code.");

    property p_ready;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (run_ok && !s.in_reset && !s.ready)
        |=> s.ready;
    endproperty
    a_ready: assert property (p_ready) // R12
        else $error("Serial interface did not resume.");

    property p_async_ignore;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && s.async_mode)
        |=> !s.pend_load;
    endproperty
    a_async_ignore: assert property (p_async_ignore) // R16
        else $error("Load taken in asynchronous mode.");

    property p_async_write;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (run_ok && s.async_mode && !correction_engine_enable_in && s.cs_sync[1] && !s.cs_prev
         && wr_in.valid) |=> s.latch[$past(wr_in.chan)] == $past(wr_in.data);
    endproperty
    a_async_write: assert property (p_async_write) // R16
        else $error("Latch not updated on select rising.");

    property p_async_corr;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (run_ok && s.async_mode && correction_engine_enable_in && corr_done_in)
        |=> s.latch[$past(corr_chan_in)] == $past(s.data_reg[corr_chan_in]);
    endproperty
    a_async_corr: assert property (p_async_corr) // R17
        else $error("Latch not updated after correction.");

    property p_sync_all;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (run_ok && !s.async_mode && s.pend_load && !correction_engine_enable_in)
        |=> !s.pend_load && s.accessed == '0;
    endproperty
    a_sync_all: assert property (p_sync_all) // R18
        else $error("Pending load not applied.");

    property p_sync_wait;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (run_ok && s.pend_load && correction_engine_enable_in && !corr_done_in)
        |=> s.pend_load && $stable(s.latch);
    endproperty
    a_sync_wait: assert property (p_sync_wait) // R19
        else $error("Load applied before correction finished.");

    property p_idle_latch;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (run_ok && !s.async_mode && !s.pend_load)
        |=> $stable(s.latch);
    endproperty
    a_idle_latch: assert property (p_idle_latch) // R15
        else $error("Latch changed without a load.");

    property p_clr_release;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && s.clr_state == duc_pkg::DUC_CLEARED && s.clr_sync[1] && !s.ld_sync[1])
        |=> s.clr_state == duc_pkg::DUC_NORMAL;
    endproperty
    a_clr_release: assert property (p_clr_release) // R4
        else $error("Outputs not restored with strobe low.");

    property p_write;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (run_ok && s.cs_sync[1] && !s.cs_prev && wr_in.valid)
        |=> s.data_reg[$past(wr_in.chan)] == $past(wr_in.data);
    endproperty
    a_write: assert property (p_write) // R23
        else $error("Data register not written on select rising.");

    property p_rst_release;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clk_en_in && $rose(s.rst_sync[1]))
        |=> !serial_enable_out;
    endproperty
    a_rst_release: assert property (p_rst_release) // R24
        else $error("Serial enabled in the release cycle.");

    property p_input_hold;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (run_ok && !s.clr_sync[1] && !(s.cs_sync[1] && !s.cs_prev))
        |=> $stable(s.input_reg);
    endproperty
    a_input_hold: assert property (p_input_hold) // R5
        else $error("Clear altered the input register.");
endmodule

// file: verif/duc_host_model.sv
`timescale 1ns/1ps
// Host side of the serial strobe pair; chip select idles high, so hardware reset never
// sees a transfer in flight.
module duc_host_model (
    input  wire logic           clk_in,
    output logic                chip_select_n_out,
    output duc_pkg::duc_write_t wr_out,
    output logic                input_reg_wr_out
);
    initial begin
        chip_select_n_out = 1'b1;
        wr_out            = '0;
        input_reg_wr_out  = 1'b0;
    end

    // The payload is scrambled once its hold time is over, so stale data cannot pass.
    task automatic write(input logic [2:0] ch, input logic [11:0] d, input logic ir);
        @(posedge clk_in);
        chip_select_n_out <= 1'b0;
        wr_out            <= {1'b1, ch, d};
        input_reg_wr_out  <= ir;
        repeat (4) @(posedge clk_in);
        chip_select_n_out <= 1'b1;
        repeat (6) @(posedge clk_in);
        wr_out            <= {1'b0, ~ch, ~d};
        input_reg_wr_out  <= 1'b0;
    endtask
endmodule

// file: verif/tb_duc_update_ctrl.sv
`timescale 1ns/1ps
module tb_duc_update_ctrl;
    logic                mclk_in = 1'b0;
    logic                sys_rst_in = 1'b1;
    logic                hw_reset_n = 1'b1;
    logic                clear_n = 1'b1;
    logic                strobe_n = 1'b1;
    logic                level_sel = 1'b1;
    logic                sw_load = 1'b0;
    logic                corr_en = 1'b0;
    logic [1:0]          pd = 2'h0;
    logic                mon_en = 1'b0;
    logic [3:0]          mon_sel = 4'h0;
    logic                corr_done = 1'b0;
    logic [2:0]          corr_chan = 3'h0;
    logic                cs_n;
    logic                ir_wr;
    duc_pkg::duc_write_t wr;
    logic [95:0]         code;
    logic [7:0]          gnd;
    logic [11:0]         offset;
    logic [11:0]         in_reg;
    logic                ser_en;
    logic                sdo_oe;
    logic                mon_oe;
    logic [3:0]          mon_out;
    logic                async_m;
    int                  n_mismatch = 0;
    int                  cmp_count = 0;
    int                  cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    always #5 mclk_in = ~mclk_in;
    duc_host_model i_duc_host_model (.clk_in(mclk_in), .chip_select_n_out(cs_n), .wr_out(wr),
        .input_reg_wr_out(ir_wr));
    duc_update_ctrl i_duc_update_ctrl (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(1'b1), .hw_reset_n_in(hw_reset_n), .output_clear_n_in(clear_n),
        .load_strobe_n_in(strobe_n), .chip_select_n_in(cs_n), .reset_level_select_in(level_sel),
        .data_format_select_in(1'b0), .single_supply_in(1'b0), .wr_in(wr),
        .input_reg_wr_in(ir_wr), .software_load_bit_in(sw_load),
        .correction_engine_enable_in(corr_en), .corr_done_in(corr_done), .corr_chan_in(corr_chan),
        .group_powerdown_bit_in(pd), .monitor_enable_in(mon_en), .monitor_select_in(mon_sel),
        .channel_output_code_out(code), .channel_output_ground_out(gnd),
        .offset_code_out(offset), .input_reg_out(in_reg), .serial_enable_out(ser_en),
        .sdo_oe_out(sdo_oe), .monitor_output_oe_out(mon_oe), .monitor_output_sel_out(mon_out),
        .async_mode_out(async_m));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [11:0] ch(input int i);
        return code[12*i +: 12];
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic wrap_up();
        $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Straight binary with high select gives midscale data and the binary offset.
    task automatic t_reset(input logic strobe);
        @(posedge mclk_in);
        sys_rst_in <= 1'b1;
        strobe_n   <= strobe;
        cyc(16);
        sys_rst_in <= 1'b0;
        hw_reset_n <= 1'b0;
        cyc(6);
        chk({11'h0, ser_en}, 12'h000);
        chk({11'h0, sdo_oe}, 12'h000);
        hw_reset_n <= 1'b1;
        for (int k = 0; k < 20 && ser_en !== 1'b1; k++) @(posedge mclk_in);
        chk({11'h0, ser_en}, 12'h001);
        for (int i = 0; i < 8; i++) chk(ch(i), 12'h800);
        chk(offset, 12'h99A);
        chk(in_reg, 12'h000);
        chk({11'h0, async_m}, {11'h0, ~strobe});
    endtask
    // Strobe goes low after the first write and stays low, so the clear release is the tied-low case.
    task automatic t_async();
        strobe_n <= 1'b1;
        i_duc_host_model.write(3'h3, 12'h5A5, 1'b1);
        strobe_n <= 1'b0;
        cyc(4);
        chk(ch(3), 12'h5A5);
        chk(ch(2), 12'h800);
        chk(in_reg, 12'h5A5);
        clear_n <= 1'b0;
        cyc(8);
        chk({4'h0, gnd}, 12'h0FF);
        clear_n <= 1'b1;
        cyc(8);
        chk({4'h0, gnd}, 12'h000);
        chk(ch(3), 12'h5A5);
        corr_en <= 1'b1;
        i_duc_host_model.write(3'h4, 12'h3C3, 1'b0);
        chk(ch(4), 12'h800);
        corr_chan <= 3'h4;
        corr_done <= 1'b1;
        cyc(1);
        corr_done <= 1'b0;
        corr_en   <= 1'b0;
        cyc(4);
        chk(ch(4), 12'h3C3);
    endtask
    task automatic t_sync_clear();
        i_duc_host_model.write(3'h1, 12'h123, 1'b0);
        cyc(4);
        chk(ch(1), 12'h800);
        clear_n <= 1'b0;
        cyc(8);
        chk({4'h0, gnd}, 12'h0FF);
        strobe_n <= 1'b0;
        cyc(4);
        strobe_n <= 1'b1;
        cyc(6);
        clear_n <= 1'b1;
        cyc(8);
        chk({4'h0, gnd}, 12'h0FF);
        strobe_n <= 1'b0;
        cyc(8);
        chk({4'h0, gnd}, 12'h000);
        chk(ch(1), 12'h123);
        chk(ch(0), 12'h800);
        strobe_n <= 1'b1;
    endtask
    task automatic t_sync_soft();
        i_duc_host_model.write(3'h5, 12'hABC, 1'b0);
        cyc(4);
        chk(ch(5), 12'h800);
        sw_load <= 1'b1;
        cyc(3);
        sw_load <= 1'b0;
        cyc(6);
        chk(ch(5), 12'hABC);
    endtask
    // With correction on, the pending load must wait for the engine's done pulse.
    task automatic t_sync_corr();
        i_duc_host_model.write(3'h6, 12'h321, 1'b0);
        corr_en <= 1'b1;
        sw_load <= 1'b1;
        cyc(1);
        sw_load <= 1'b0;
        cyc(6);
        chk(ch(6), 12'h800);
        corr_chan <= 3'h6;
        corr_done <= 1'b1;
        cyc(1);
        corr_done <= 1'b0;
        corr_en   <= 1'b0;
        cyc(4);
        chk(ch(6), 12'h321);
        chk(ch(0), 12'h800);
    endtask
    task automatic t_pd_mon();
        pd <= 2'h1;
        cyc(8);
        chk({4'h0, gnd}, 12'h00F);
        pd <= 2'h0;
        for (int k = 0; k < 20010 && gnd !== 8'h00; k++) @(posedge mclk_in);
        chk({4'h0, gnd}, 12'h000);
        cyc(4);
        chk({11'h0, mon_oe}, 12'h000);
        mon_en  <= 1'b1;
        mon_sel <= duc_pkg::MON_SRC_REFA;
        cyc(6);
        chk({11'h0, mon_oe}, 12'h001);
        chk({8'h0, mon_out}, 12'h00C);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        t_reset(1'b0);
        t_async();
        t_reset(1'b1);
        t_sync_clear();
        t_sync_soft();
        t_sync_corr();
        t_pd_mon();
        wrap_up();
    end
endmodule
